// >>> supply_integrity_pkg.sv
// Constants shared by the supply integrity monitor.
// Assumes an 8-bit register port and one 25 MHz clock.
package supply_integrity_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;

  // Register port addresses
  localparam logic [7:0] CSR_ADDR = 8'h00;
  localparam logic [7:0] EVT_STATUS_ADDR = 8'h01;
  localparam logic [7:0] EVT_MASK_ADDR = 8'h02;

  // Control/status register fields
  localparam int unsigned CSR_IRQ_EN_BIT = 0;
  localparam int unsigned CSR_WARN_BIT = 1;
  localparam int unsigned CSR_BO_FLAG_BIT = 2;
  localparam int unsigned CSR_LOCK_BIT = 3;
  localparam int unsigned CSR_DOG_FLAG_BIT = 4;

  // Reset values of stored fields
  localparam logic RESET_IRQ_EN = 1'b0;
  localparam logic RESET_DOG_FLAG = 1'b0;
  localparam logic RESET_BO_FLAG = 1'b0;
  localparam logic [4:0] RESET_EVT_MASK = 5'h00;

  // Event status and mask layout
  localparam int unsigned EVT_WIDTH = 5;
  localparam int unsigned EVT_WARN = 0;
  localparam int unsigned EVT_BROWNOUT = 1;
  localparam int unsigned EVT_DOG = 2;
  localparam int unsigned EVT_EXT = 3;
  localparam int unsigned EVT_LOCK_LOSS = 4;

  // Synchroniser lanes
  localparam int unsigned SYNC_BO = 0;
  localparam int unsigned SYNC_WARN = 1;
  localparam int unsigned SYNC_LOCK = 2;

  // Brownout threshold option codes
  typedef enum logic [1:0] {
    LEVEL_LOW = 2'b00,
    LEVEL_MEDIUM = 2'b01,
    LEVEL_HIGH = 2'b10
  } brownout_level_t;

endpackage

// >>> supply_integrity_monitor.sv
// Digital side of the supply integrity unit: brownout reset, supply warning,
// reset-cause flags, PLL lock flag and the control/status register.
// Assumes analog comparators and the PLL lock are asynchronous levels; all
// other inputs are synchronous to ref_clk_in. rst_in is the cold start only.
//
// Behaviour
// RULE_01: Hold chip in static reset while brownout detector reports low supply.
// RULE_02: Pull the external reset pin low during a brownout reset.
// RULE_03: Brownout detector active only when option enables; option picks one of three levels.
// RULE_04: Warning flag shows comparator level unlatched: 1 under threshold, 0 over.
// RULE_05: Warning detector and flag work only while brownout detector enabled.
// RULE_06: Rising warning flag with enable set raises interrupt; software owns the enable.
// RULE_07: Entering the warning service routine clears the pending warning request.
// RULE_08: Block runs normally in WAIT; warning interrupt wakes the CPU.
// RULE_09: In HALT register frozen, detector active, warning does not wake.
// RULE_10: Watchdog reset sets dog flag; software zero write or brownout clears it.
// RULE_11: Brownout reset sets brownout flag; reading the register clears it.
// RULE_12: External or watchdog reset leaves the brownout flag unchanged.
// RULE_13: Cause coding: 00 external, dog only watchdog, brownout flag brownout.
// RULE_14: Brownout flag value carries no meaning while detector disabled.
// RULE_15: PLL lock flag driven by hardware: 1 locked, 0 not locked.
// RULE_16: Software writes upper three bits as zero; they read as zero.
// RULE_17: After reset upper three bits and enable read zero.
// RULE_18: Comparator and lock inputs pass two flip-flops before use.
module supply_integrity_monitor
  import supply_integrity_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic brownout_enable_opt_in,
  input wire logic [1:0] brownout_level_opt_in,
  output logic [1:0] brownout_level_out,
  input wire logic brownout_cmp_in,
  input wire logic warn_cmp_in,
  input wire logic pll_lock_in,
  input wire logic dog_reset_in,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe_out,
  output logic chip_reset_out,
  input wire logic halt_in,
  input wire logic isr_enter_in,
  output logic warn_irq_out,
  output logic warn_wake_out,
  output logic irq_out
);

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic warn_prev;
    logic lock_prev;
    logic dog_prev;
    logic ext_prev;
    logic warn_shown;
    logic lock_shown;
    logic irq_en;
    logic dog_flag;
    logic bo_flag;
    logic warn_pend;
    logic bo_active;
    logic [1:0] level;
    logic [EVT_WIDTH-1:0] evt_status;
    logic [EVT_WIDTH-1:0] evt_mask;
    logic [7:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic bo_now;
  logic warn_now;
  logic ext_now;
  logic warn_rise;
  logic any_reset;
  logic csr_rd;
  logic csr_wr;

  function automatic logic [7:0] csr_value(input state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[CSR_IRQ_EN_BIT] = s.irq_en;
    v[CSR_WARN_BIT] = s.warn_shown;
    // RULE_13 cause coded by two flags
    v[CSR_BO_FLAG_BIT] = s.bo_flag;
    v[CSR_LOCK_BIT] = s.lock_shown;
    v[CSR_DOG_FLAG_BIT] = s.dog_flag;
    return v;
  endfunction

  // RULE_03 detector gated by option
  assign bo_now = brownout_enable_opt_in & state_reg.sync2[SYNC_BO];
  // RULE_05 warning only with detector
  assign warn_now = brownout_enable_opt_in & state_reg.sync2[SYNC_WARN];
  // Pin low from outside while we are not pulling it
  assign ext_now = ~reset_pin_in & ~state_reg.bo_active;
  assign warn_rise = warn_now & ~state_reg.warn_prev;
  assign any_reset = bo_now | dog_reset_in | ext_now;
  assign csr_rd = rd_in & (addr_in == CSR_ADDR);
  assign csr_wr = wr_in & (addr_in == CSR_ADDR);

  always_comb begin
    logic [EVT_WIDTH-1:0] evt_set;
    evt_set = '0;
    state_next = state_reg;
    // RULE_18 two-stage synchronisers
    state_next.sync1 = {pll_lock_in, warn_cmp_in, brownout_cmp_in};
    state_next.sync2 = state_reg.sync1;
    state_next.warn_prev = warn_now;
    state_next.lock_prev = state_reg.sync2[SYNC_LOCK];
    state_next.dog_prev = dog_reset_in;
    state_next.ext_prev = ext_now;
    // RULE_01 static brownout reset
    state_next.bo_active = bo_now;
    // RULE_03 threshold select
    state_next.level = brownout_level_opt_in;

    // Event sources for the summary interrupt
    evt_set[EVT_WARN] = warn_rise;
    evt_set[EVT_BROWNOUT] = bo_now & ~state_reg.bo_active;
    evt_set[EVT_DOG] = dog_reset_in & ~state_reg.dog_prev;
    evt_set[EVT_EXT] = ext_now & ~state_reg.ext_prev;
    evt_set[EVT_LOCK_LOSS] = state_reg.lock_prev & ~state_reg.sync2[SYNC_LOCK];

    // RULE_09 frozen in halt, resets still act
    if (!halt_in) begin
      // RULE_04 live comparator level
      state_next.warn_shown = warn_now;
      // RULE_15 hardware lock flag
      state_next.lock_shown = state_reg.sync2[SYNC_LOCK];
      // RULE_11 read clears flag
      if (csr_rd) begin
        state_next.bo_flag = 1'b0;
      end
      if (csr_wr) begin
        // RULE_06 software owns enable
        state_next.irq_en = wdata_in[CSR_IRQ_EN_BIT];
        // RULE_10 zero write clears
        if (!wdata_in[CSR_DOG_FLAG_BIT]) begin
          state_next.dog_flag = 1'b0;
        end
      end
    end

    // RULE_07 cleared on service entry
    if (isr_enter_in) begin
      state_next.warn_pend = 1'b0;
    end
    // RULE_06 pending on rising flag, set beats clear
    if (warn_rise) begin
      state_next.warn_pend = 1'b1;
    end

    // RULE_10 brownout clears dog flag
    if (bo_now) begin
      state_next.dog_flag = 1'b0;
    end
    // RULE_10 watchdog sets flag
    if (dog_reset_in) begin
      state_next.dog_flag = 1'b1;
    end
    // RULE_14 detector off leaves the flag as it stood
    // RULE_12 of the resets only brownout touches this flag
    if (bo_now) begin
      state_next.bo_flag = 1'b1;
    end
    // RULE_17 any chip reset clears the enable
    if (any_reset) begin
      state_next.irq_en = RESET_IRQ_EN;
    end

    // Register port; reads of the event status clear what they return
    state_next.rdata = 8'h00;
    if (rd_in) begin
      if (addr_in == CSR_ADDR) begin
        // RULE_16 upper bits read zero
        state_next.rdata = csr_value(state_reg);
      end else if (addr_in == EVT_STATUS_ADDR) begin
        state_next.rdata = {3'h0, state_reg.evt_status};
      end else if (addr_in == EVT_MASK_ADDR) begin
        state_next.rdata = {3'h0, state_reg.evt_mask};
      end else begin
        state_next.rdata = 8'h00;
      end
    end
    if (wr_in && (addr_in == EVT_MASK_ADDR)) begin
      state_next.evt_mask = wdata_in[EVT_WIDTH-1:0];
    end
    if (rd_in && (addr_in == EVT_STATUS_ADDR)) begin
      state_next.evt_status = evt_set;
    end else begin
      state_next.evt_status = state_reg.evt_status | evt_set;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_reg <= '{
        sync1: 3'h0, sync2: 3'h0, warn_prev: 1'b0, lock_prev: 1'b0,
        dog_prev: 1'b0, ext_prev: 1'b0, warn_shown: 1'b0, lock_shown: 1'b0,
        irq_en: RESET_IRQ_EN, dog_flag: RESET_DOG_FLAG, bo_flag: RESET_BO_FLAG,
        warn_pend: 1'b0, bo_active: 1'b0, level: LEVEL_LOW,
        evt_status: 5'h00, evt_mask: RESET_EVT_MASK, rdata: 8'h00
      };
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_out = state_reg.rdata;
  assign brownout_level_out = state_reg.level;
  // RULE_01 core held in reset
  assign chip_reset_out = state_reg.bo_active;
  // RULE_02 open-drain pull low
  assign reset_pin_oe_out = state_reg.bo_active;
  assign reset_pin_out = 1'b0;
  assign warn_irq_out = state_reg.warn_pend & state_reg.irq_en;
  // RULE_08 wakes from wait, RULE_09 not from halt
  assign warn_wake_out = warn_irq_out & ~halt_in;
  assign irq_out = |(state_reg.evt_status & state_reg.evt_mask);

  // Cold start only; chip resets are events here, so assertions stay armed through them
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  property p_bo_hold;
    (brownout_enable_opt_in && brownout_cmp_in)[*4] |-> chip_reset_out;
  endproperty
  a_bo_hold: assert property (p_bo_hold) else $error("brownout did not hold reset"); // RULE_01

  property p_pin_low;
    chip_reset_out |-> reset_pin_oe_out && !reset_pin_out;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("reset pin not pulled low"); // RULE_02

  property p_bo_disabled;
    (!brownout_enable_opt_in)[*2] |-> !chip_reset_out;
  endproperty
  a_bo_disabled: assert property (p_bo_disabled) else $error("reset while detector disabled"); // RULE_03

  property p_warn_level;
    (brownout_enable_opt_in && !halt_in && warn_cmp_in)[*4] |=> state_reg.warn_shown;
  endproperty
  a_warn_level: assert property (p_warn_level) else $error("warning flag not following comparator"); // RULE_04

  property p_warn_off;
    (!brownout_enable_opt_in && !halt_in)[*2] |-> !state_reg.warn_shown;
  endproperty
  a_warn_off: assert property (p_warn_off) else $error("warning flag set while detector disabled"); // RULE_05

  property p_warn_irq;
    (warn_now && !state_reg.warn_prev && state_reg.irq_en && !any_reset && !(csr_wr && !halt_in))
      |=> warn_irq_out;
  endproperty
  a_warn_irq: assert property (p_warn_irq) else $error("warning interrupt not raised"); // RULE_06

  property p_isr_clear;
    (isr_enter_in && !warn_rise) |=> !warn_irq_out;
  endproperty
  a_isr_clear: assert property (p_isr_clear) else $error("pending request survived service entry"); // RULE_07

  property p_halt_freeze;
    (halt_in && !any_reset) |=> $stable(state_reg.irq_en) && $stable(state_reg.warn_shown)
      && $stable(state_reg.bo_flag) && $stable(state_reg.dog_flag) && $stable(state_reg.lock_shown);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("register changed in halt"); // RULE_09

  property p_dog_set;
    dog_reset_in |=> state_reg.dog_flag;
  endproperty
  a_dog_set: assert property (p_dog_set) else $error("dog flag not set"); // RULE_10

  property p_dog_clear_bo;
    (bo_now && !dog_reset_in) |=> !state_reg.dog_flag;
  endproperty
  a_dog_clear_bo: assert property (p_dog_clear_bo) else $error("brownout left dog flag set"); // RULE_10

  property p_bo_flag_read;
    (csr_rd && !halt_in && !bo_now) |=> !state_reg.bo_flag ##1 !rdata_out[CSR_BO_FLAG_BIT];
  endproperty
  a_bo_flag_read: assert property (p_bo_flag_read) else $error("read did not clear brownout flag"); // RULE_11

  property p_bo_flag_keep;
    ((dog_reset_in || ext_now) && !bo_now && !csr_rd) |=> $stable(state_reg.bo_flag);
  endproperty
  a_bo_flag_keep: assert property (p_bo_flag_keep) else $error("other reset changed brownout flag"); // RULE_12

  property p_lock;
    (pll_lock_in && !halt_in)[*4] |=> rd_in ##0 csr_rd |=> rdata_out[CSR_LOCK_BIT];
  endproperty
  a_lock: assert property (p_lock) else $error("lock flag not shown"); // RULE_15

  property p_upper_zero;
    $past(csr_rd) |-> rdata_out[7:5] == 3'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero"); // RULE_16

  property p_enable_reset;
    any_reset |=> !state_reg.irq_en;
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("enable survived reset"); // RULE_17

  // Two stages: a single flop would let a fresh level through one cycle early
  property p_bo_sync;
    (!brownout_cmp_in)[*3] ##1 brownout_cmp_in |=> !chip_reset_out;
  endproperty
  a_bo_sync: assert property (p_bo_sync) else $error("brownout reached reset too early"); // RULE_18

  property p_lock_sync;
    (!pll_lock_in)[*3] ##1 pll_lock_in |=> !state_reg.sync2[SYNC_LOCK];
  endproperty
  a_lock_sync: assert property (p_lock_sync) else $error("lock passed fewer than two stages"); // RULE_18

  property p_bo_release;
    (!brownout_cmp_in)[*4] |-> !chip_reset_out;
  endproperty
  a_bo_release: assert property (p_bo_release) else $error("reset held with supply good"); // RULE_01

  property p_pin_release;
    !chip_reset_out |-> !reset_pin_oe_out;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("reset pin driven outside brownout"); // RULE_02

  property p_warn_clear;
    (brownout_enable_opt_in && !halt_in && !warn_cmp_in)[*4] |=> !state_reg.warn_shown;
  endproperty
  a_warn_clear: assert property (p_warn_clear) else $error("warning flag stuck high"); // RULE_04

  property p_enable_write;
    (csr_wr && !halt_in && !any_reset) |=> state_reg.irq_en == $past(wdata_in[CSR_IRQ_EN_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable bit not written"); // RULE_06

  // A masked CPU must not lose the request; only service entry drops it
  property p_pend_hold;
    (state_reg.warn_pend && !isr_enter_in) |=> state_reg.warn_pend;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending warning lost"); // RULE_06

  property p_wake_wait;
    (warn_irq_out && !halt_in) |-> warn_wake_out;
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("warning did not wake from wait"); // RULE_08

  property p_halt_no_wake;
    halt_in |-> !warn_wake_out;
  endproperty
  a_halt_no_wake: assert property (p_halt_no_wake) else $error("warning woke from halt"); // RULE_09

  property p_dog_zero;
    (csr_wr && !halt_in && !wdata_in[CSR_DOG_FLAG_BIT] && !dog_reset_in) |=> !state_reg.dog_flag;
  endproperty
  a_dog_zero: assert property (p_dog_zero) else $error("zero write left dog flag set"); // RULE_10

  property p_cause_bo;
    (bo_now && !dog_reset_in) |=> state_reg.bo_flag && !state_reg.dog_flag;
  endproperty
  a_cause_bo: assert property (p_cause_bo) else $error("brownout cause not coded"); // RULE_13

  property p_bo_flag_off;
    (!brownout_enable_opt_in && !csr_rd) |=> $stable(state_reg.bo_flag);
  endproperty
  a_bo_flag_off: assert property (p_bo_flag_off) else $error("brownout flag moved while disabled"); // RULE_14

  property p_lock_off;
    (!pll_lock_in && !halt_in)[*4] |=> !state_reg.lock_shown;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock flag stuck high"); // RULE_15

  c_brownout: cover property ($rose(chip_reset_out));
  c_warn_irq: cover property ($rose(warn_irq_out) ##[1:20] isr_enter_in);
  c_dog_then_bo: cover property (dog_reset_in ##[1:50] bo_now);
  c_read_clear: cover property (state_reg.bo_flag && csr_rd);
  c_halt_rise: cover property (halt_in && warn_rise);

endmodule

// >>> cpu_model.sv
// CPU interrupt entry and external reset pin model.
// Assumes the warning request is a registered level from the monitor.
module cpu_model (
  input wire logic clk_in,
  input wire logic warn_irq_in,
  input wire logic mask_in,
  input wire logic pin_oe_in,
  input wire logic pin_drv_in,
  input wire logic ext_low_in,
  output logic isr_enter_out = 1'b0,
  output logic pin_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Single entry pulse
  // The pulse lasts one cycle so a request that is still pending is not entered twice.
  always @(posedge clk_in) isr_enter_out <= warn_irq_in && !mask_in && !isr_enter_out;
  assign pin_level_out = !(ext_low_in || (pin_oe_in && !pin_drv_in));
endmodule

// >>> supply_integrity_monitor_test.sv
// Bench for the supply integrity monitor with a CPU model.
// Assumes two synchroniser stages and one register stage on analog and lock inputs.
module supply_integrity_monitor_test;
  import supply_integrity_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bo_en = 1'b1;
  logic [1:0] lvl = 2'b00;
  logic bo_cmp = 1'b0;
  logic warn_cmp = 1'b0;
  logic lock = 1'b0;
  logic dog = 1'b0;
  logic halt = 1'b0;
  logic mask = 1'b1;
  logic ext_low = 1'b0;
  logic isr, pin, pin_drv, pin_oe, chip_rst, warn_irq, wake, irq;
  logic [7:0] rdata;
  logic [1:0] lvl_out;
  int errors = 0;
  int check_count = 0;
  initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  supply_integrity_monitor supply_integrity_monitor_inst (.ref_clk_in(clk), .rst_in(rst), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .brownout_enable_opt_in(bo_en),
    .brownout_level_opt_in(lvl), .brownout_level_out(lvl_out), .brownout_cmp_in(bo_cmp),
    .warn_cmp_in(warn_cmp), .pll_lock_in(lock), .dog_reset_in(dog), .reset_pin_in(pin),
    .reset_pin_out(pin_drv), .reset_pin_oe_out(pin_oe), .chip_reset_out(chip_rst), .halt_in(halt),
    .isr_enter_in(isr), .warn_irq_out(warn_irq), .warn_wake_out(wake), .irq_out(irq));
  cpu_model cpu_model_inst (.clk_in(clk), .warn_irq_in(warn_irq), .mask_in(mask), .pin_oe_in(pin_oe),
    .pin_drv_in(pin_drv), .ext_low_in(ext_low), .isr_enter_out(isr), .pin_level_out(pin));
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [7:0] exp, string name);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // Read data lands at this edge; let it settle before taking it
    #1;
    check(name, exp, rdata);
  endtask
  // Short chip reset pulses; the brownout one waits out the synchroniser
  task automatic pulse(int which);
    @(posedge clk);
    if (which == 0) dog <= 1'b1;
    else if (which == 1) ext_low <= 1'b1;
    else bo_cmp <= 1'b1;
    tick(4);
    dog <= 1'b0;
    ext_low <= 1'b0;
    bo_cmp <= 1'b0;
    tick(4);
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    tick(20);
    rst <= 1'b0;
    rd_reg(CSR_ADDR, 8'h00, "csr reset");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      lvl <= 2'(i);
      tick(2);
      check("level", 8'(i), {6'h00, lvl_out});
    end
    wr_reg(CSR_ADDR, 8'h11);
    rd_reg(CSR_ADDR, 8'h01, "enable only");
    @(posedge clk);
    lock <= 1'b1;
    warn_cmp <= 1'b1;
    tick(5);
    check("irq held by mask", 8'h01, {7'h00, warn_irq});
    check("wake", 8'h01, {7'h00, wake});
    rd_reg(CSR_ADDR, 8'h0B, "warn lock");
    @(posedge clk);
    mask <= 1'b0;
    tick(4);
    check("irq serviced", 8'h00, {7'h00, warn_irq});
    @(posedge clk);
    mask <= 1'b1;
    warn_cmp <= 1'b0;
    pulse(0);
    rd_reg(CSR_ADDR, 8'h18, "dog cause");
    wr_reg(CSR_ADDR, 8'h00);
    rd_reg(CSR_ADDR, 8'h08, "dog clear");
    pulse(0);
    @(posedge clk);
    bo_cmp <= 1'b1;
    tick(4);
    check("chip reset", 8'h01, {7'h00, chip_rst});
    check("pin low", 8'h00, {7'h00, pin});
    @(posedge clk);
    bo_cmp <= 1'b0;
    tick(4);
    check("reset ends", 8'h00, {7'h00, chip_rst});
    rd_reg(CSR_ADDR, 8'h0C, "bo cause");
    pulse(2);
    pulse(0);
    pulse(1);
    rd_reg(CSR_ADDR, 8'h1C, "bo kept");
    rd_reg(CSR_ADDR, 8'h18, "read clear");
    wr_reg(CSR_ADDR, 8'h11);
    @(posedge clk);
    halt <= 1'b1;
    warn_cmp <= 1'b1;
    wr_reg(CSR_ADDR, 8'h00);
    tick(5);
    check("halt no wake", 8'h00, {7'h00, wake});
    rd_reg(CSR_ADDR, 8'h19, "frozen");
    @(posedge clk);
    halt <= 1'b0;
    bo_en <= 1'b0;
    bo_cmp <= 1'b1;
    tick(5);
    check("no bo reset", 8'h00, {7'h00, chip_rst});
    rd_reg(EVT_STATUS_ADDR, 8'h0F, "events");
    wr_reg(EVT_MASK_ADDR, 8'h1F);
    rd_reg(8'h07, 8'h00, "unmapped");
    @(posedge clk);
    lock <= 1'b0;
    tick(5);
    check("lock loss irq", 8'h01, {7'h00, irq});
    rd_reg(EVT_STATUS_ADDR, 8'h10, "lock event");
    check("irq cleared", 8'h00, {7'h00, irq});
    complete_run();
  end
endmodule
